// >>> testbench/asp_port_props.sv
// Purpose: bus and line checks for the serial port
// Assumes: sees only the port pins
// Notes: write tracking stands in for hidden control state
`timescale 1ns/1ps
module asp_port_props #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // bus
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [2:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    input wire [31:0] dat_o,
    input wire ack_o,
    // line, dma, irq
    input wire rx_i,
    input wire cts_n_i,
    input wire tx_o,
    input wire rts_n_o,
    input wire dma_tx_req_o,
    input wire dma_rx_req_o,
    input wire irq_o
);
    reg tx_any_reg;
    reg mask_any_reg;
    // only relaxes once set, so a software reset cannot cause false fires
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_any_reg <= 1'h0;
            mask_any_reg <= 1'h0;
        end else if (cyc_i && stb_i && we_i) begin
            if (adr_i <= 3'h2) tx_any_reg <= 1'h1;
            if (adr_i == 3'h7) mask_any_reg <= 1'h1;
        end
    end
    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o)
        else $error("ack held two cycles");
    ack_follow_a: assert property (@(posedge clk_i) disable iff (rst_i) cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack late");
    ack_cause_a: assert property (@(posedge clk_i) disable iff (rst_i) $rose(ack_o) |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    rdata_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) !ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    reset_idle_a: assert property (@(posedge clk_i) rst_i |=> tx_o && rts_n_o && !irq_o && !dma_rx_req_o)
        else $error("outputs not idle after reset");
    tx_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) !tx_any_reg |-> tx_o)
        else $error("line moved without a write");
    irq_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) !mask_any_reg |-> !irq_o)
        else $error("irq with mask clear");
    start_width_a: assert property (@(posedge clk_i) disable iff (rst_i) $fell(tx_o) |=> !tx_o [*7])
        else $error("low level too short");
endmodule
bind asp_port asp_port_props #(.DEPTH(DEPTH), .AW(AW)) u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rx_i(rx_i), .cts_n_i(cts_n_i), .tx_o(tx_o), .rts_n_o(rts_n_o), .dma_tx_req_o(dma_tx_req_o),
    .dma_rx_req_o(dma_rx_req_o), .irq_o(irq_o));

// >>> testbench/asp_serial_peer.sv
// Purpose: remote serial party model
// Assumes: bt is the bit time in clocks, nb the bits after start less stop
// Notes: decoded word is {stop, parity, data}, lsb first
`timescale 1ns/1ps
module asp_serial_peer (
    // clock
    input wire clk_i,
    // line
    input wire tx_i,
    output reg rx_o,
    output reg cts_n_o
);
    int bt = 32;
    int nb = 8;
    bit listen = 1;
    logic [9:0] rxq[$];
    int fallq[$];
    initial begin
        rx_o = 1'h1;
        cts_n_o = 1'h1;
    end
    always @(negedge tx_i) if (listen) begin : dec
        logic [9:0] w;
        w = 10'h0;
        fallq.push_back(int'($time / 100));
        repeat (bt / 2) @(posedge clk_i);
        for (int i = 0; i <= nb; i++) begin
            repeat (bt) @(posedge clk_i);
            w[i] = tx_i;
        end
        rxq.push_back(w);
    end
    task automatic send(input logic [9:0] w, input int n);
        for (int i = 0; i <= n; i++) begin
            rx_o <= (i == 0) ? 1'h0 : w[i-1];
            repeat (bt) @(posedge clk_i);
        end
        rx_o <= 1'h1;
        repeat (bt) @(posedge clk_i);
    endtask
endmodule

// >>> testbench/async_serial_port_tb_top.sv
// Purpose: self-checking bench for the serial port
// Assumes: peer model drives rx and cts and decodes tx
// Notes: divisor kept at 1..3 so frames stay short
`timescale 1ns/1ps
module async_serial_port_tb_top;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [2:0] adr_i = 0;
    logic [3:0] sel_i = 0;
    logic [31:0] dat_i = 0, dat_o, q;
    logic ack_o, rx_i, cts_n_i, tx_o, rts_n_o, dtx, drx, irq_o, pe;
    int fail_count = 0, cmp_count = 0, seed = 12318, bt, dv, t;
    logic [7:0] d;
    logic [3:0] c;
    logic [1:0] s;
    always #50 clk_i = ~clk_i;
    asp_port uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .rx_i(rx_i), .cts_n_i(cts_n_i), .tx_o(tx_o),
        .rts_n_o(rts_n_o), .dma_tx_req_o(dtx), .dma_rx_req_o(drx), .irq_o(irq_o));
    asp_serial_peer peer (.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i), .cts_n_o(cts_n_i));
    function automatic logic [7:0] msk(input logic [7:0] v, input logic [3:0] k);
        return v & ((8'h1 << (k[1:0] + 5)) - 8'h1);
    endfunction
    function automatic logic [9:0] frame(input logic [7:0] v, input logic [3:0] k);
        logic [9:0] w;
        int n;
        n = k[1:0] + 5;
        w = msk(v, k);
        w[n] = k[2] ? (k[3] ? ^msk(v, k) : ~^msk(v, k)) : 1'h1;
        if (k[2]) w[n+1] = 1'h1;
        return w;
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [2:0] a, input logic [31:0] v);
        int k;
        k = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, 4'hf, v};
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'h1 && k < 50);
        q = dat_o;
        if (k >= 50) cmp("ack", 32'h1, 32'h0);
        {cyc_i, stb_i} <= 2'h0;
    endtask
    task automatic rd(input string n, input logic [2:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0);
        cmp(n, e, q);
    endtask
    task automatic wait_peer(input int n);
        for (t = 0; t < 9000 && peer.rxq.size() < n; t++) @(posedge clk_i);
    endtask
    task automatic pulse(input logic [31:0] e);
        int w;
        w = 0;
        wb(1'h1, 3'h0, 32'h0);
        for (t = 0; t < 2000 && tx_o !== 1'h1; t++) @(posedge clk_i);
        for (t = 0; t < 2000 && tx_o === 1'h1; t++) begin
            @(posedge clk_i);
            w++;
        end
        cmp("ir pulse", e, w);
        repeat (12 * bt) @(posedge clk_i);
    endtask
    initial begin
        #(100 * 60000);
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        rd("ctrl", 3'h1, 32'h0);
        rd("div", 3'h4, 32'h1);
        rd("stat", 3'h5, 32'h1);
        rd("rx empty", 3'h0, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            dv = 1 + {$random(seed)} % 3;
            s = {$random(seed)} % 3;
            c = $random(seed);
            d = $random(seed);
            bt = 16 * dv;
            peer.bt = bt;
            peer.nb = c[1:0] + 5 + c[2];
            peer.rxq.delete();
            peer.fallq.delete();
            wb(1'h1, 3'h4, dv);
            wb(1'h1, 3'h1, {26'h0, s, c});
            wb(1'h1, 3'h0, {24'h0, d});
            wb(1'h1, 3'h0, {24'h0, ~d});
            wait_peer(2);
            cmp("tx word", frame(d, c), peer.rxq[0]);
            cmp("tx word", frame(~d, c), peer.rxq[1]);
            // one idle tick follows the stop bits before the next start
            cmp("span", (16 * (2 + peer.nb) + 8 * s + 1) * dv, peer.fallq[1] - peer.fallq[0]);
            pe = c[2] & i[0];
            peer.send(frame(d, c) ^ (pe << peer.nb - 1), peer.nb + 1);
            for (t = 0; t < 200 && drx !== 1'h1; t++) @(posedge clk_i);
            cmp("rx dma", 32'h1, drx);
            rd("irq", 3'h6, {29'h0, pe, 2'h3});
            rd("rx word", 3'h0, {23'h0, pe, msk(d, c)});
            wb(1'h1, 3'h6, 32'h3f);
        end
        $display("test frames done");
        wb(1'h1, 3'h1, 32'hc);
        peer.nb = 6;
        peer.send(10'h0, 10);
        repeat (4 * bt) @(posedge clk_i);
        rd("break word", 3'h0, 32'h600);
        wb(1'h1, 3'h6, 32'h3f);
        wb(1'h1, 3'h7, 32'h1);
        repeat (3) @(posedge clk_i);
        cmp("irq quiet", 32'h0, irq_o);
        wb(1'h1, 3'h0, 32'h0);
        repeat (12 * bt) @(posedge clk_i);
        cmp("irq on", 32'h1, irq_o);
        wb(1'h1, 3'h6, 32'h1);
        repeat (3) @(posedge clk_i);
        cmp("irq off", 32'h0, irq_o);
        wb(1'h1, 3'h7, 32'h0);
        $display("test irq done");
        peer.rxq.delete();
        wb(1'h1, 3'h1, 32'h880);
        repeat (3) @(posedge clk_i);
        cmp("rts", 32'h0, rts_n_o);
        for (int i = 0; i < 17; i++) wb(1'h1, 3'h0, i);
        rd("stat full", 3'h5, 32'h402);
        cmp("tx dma", 32'h0, dtx);
        cmp("cts hold", 32'h1, tx_o);
        wb(1'h1, 3'h2, 32'h400);
        rd("stat swrst", 3'h5, 32'h1);
        rd("ctrl kept", 3'h1, 32'h880);
        peer.cts_n_o <= 1'h0;
        peer.nb = 5;
        wb(1'h1, 3'h0, 32'h5a);
        wait_peer(1);
        cmp("cts go", frame(8'h5a, 4'h0), peer.rxq[0]);
        wb(1'h1, 3'h3, 32'h80);
        rd("ctrl clr", 3'h1, 32'h800);
        wb(1'h1, 3'h1, 32'h40);
        repeat (5) @(posedge clk_i);
        cmp("break tx", 32'h0, tx_o);
        peer.listen = 0;
        wb(1'h1, 3'h1, 32'h100);
        pulse(3 * dv);
        wb(1'h1, 3'h1, 32'h300);
        pulse(dv);
        $display("test flow and ir done");
        give_verdict();
    end
endmodule

// >>> verilog/asp_defs.vh
// Purpose: constants for the asynchronous serial port
// Assumes: word-addressed classic Wishbone slave, 32-bit data
// Notes: byte address = 4 * register index
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH
`define ASP_REG_DATA 3'h0
`define ASP_REG_CTRL 3'h1
`define ASP_REG_CSET 3'h2
`define ASP_REG_CCLR 3'h3
`define ASP_REG_DIV 3'h4
`define ASP_REG_STAT 3'h5
`define ASP_REG_IRQ 3'h6
`define ASP_REG_MASK 3'h7
`define ASP_CTRL_RST 16'h0000
`define ASP_DIV_RST 16'h0001
`define ASP_C_LEN_LO 0
`define ASP_C_LEN_HI 1
`define ASP_C_PEN 2
`define ASP_C_EVEN 3
`define ASP_C_STOP_LO 4
`define ASP_C_STOP_HI 5
`define ASP_C_BRK 6
`define ASP_C_FLOW 7
`define ASP_C_IR 8
`define ASP_C_IRLP 9
`define ASP_C_SWRST 10
`define ASP_C_RTS 11
`define ASP_I_THE 0
`define ASP_I_RXAV 1
`define ASP_I_PERR 2
`define ASP_I_FERR 3
`define ASP_I_BRK 4
`define ASP_I_OVR 5
`define ASP_NIRQ 6
`define ASP_OS_LAST 4'hf
`define ASP_OS_MID 4'h7
`define ASP_OS_HALF 4'h7
`define ASP_IR_PW 4'h2
`define ASP_IRLP_PW 4'h0
`define ASP_STOP_MID 5'h8
`define ASP_STOP_TWO 5'h10
`define ASP_LEN_MIN 4'h5
`endif

// >>> verilog/asp_port.v
// Purpose: asynchronous serial port with fifos, flow control, infrared pulses
// Assumes: one clock; rx and cts are asynchronous pins, synchronised here
// Notes: baud tick every divisor clocks gives the sixteen-times sample rate
`timescale 1ns/1ps
`include "asp_defs.vh"
module asp_port #(
    parameter DEPTH = 16,
    parameter AW = 4
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [2:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // serial line
    input wire rx_i,
    input wire cts_n_i,
    output reg tx_o,
    output reg rts_n_o,
    // dma and interrupt
    output reg dma_tx_req_o,
    output reg dma_rx_req_o,
    output reg irq_o
);
    // all state is per instance; the second port is a second instance
    reg [15:0] ctrl_reg;
    reg [15:0] div_reg;
    reg [15:0] bcnt_reg;
    reg tick_reg;
    reg [`ASP_NIRQ-1:0] ist_reg;
    reg [`ASP_NIRQ-1:0] mask_reg;
    reg [7:0] txf [0:DEPTH-1];
    reg [10:0] rxf [0:DEPTH-1];
    reg [AW:0] twp_reg, trp_reg, rwp_reg, rrp_reg;
    reg rx_s1_reg, rx_s2_reg, cts_s1_reg, cts_s2_reg;
    wire srst = rst_i | ctrl_reg[`ASP_C_SWRST];
    wire [AW:0] tcnt = twp_reg - trp_reg;
    wire [AW:0] rcnt = rwp_reg - rrp_reg;
    wire tfull = tcnt == DEPTH;
    wire tempty = tcnt == 0;
    wire rfull = rcnt == DEPTH;
    wire rempty = rcnt == 0;
    wire [3:0] nbits = {2'b00, ctrl_reg[`ASP_C_LEN_HI:`ASP_C_LEN_LO]} + `ASP_LEN_MIN;
    wire ir = ctrl_reg[`ASP_C_IR];
    wire bus_req = cyc_i & stb_i & ~ack_o;
    wire wr = bus_req & we_i & sel_i[0];
    wire rd = bus_req & ~we_i;
    wire tx_push = wr & (adr_i == `ASP_REG_DATA) & ~tfull;
    wire rx_pop = rd & (adr_i == `ASP_REG_DATA) & ~rempty;

    function [AW-1:0] ptr;
        input [AW:0] p;
        ptr = p[AW-1:0];
    endfunction

    // bus and control registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `ASP_CTRL_RST;
            div_reg <= `ASP_DIV_RST;
            mask_reg <= {`ASP_NIRQ{1'b0}};
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= bus_req;
            if (ctrl_reg[`ASP_C_SWRST])
                ctrl_reg[`ASP_C_SWRST] <= 1'b0; // self-clearing pulse
            if (wr) begin
                case (adr_i)
                    `ASP_REG_CTRL: ctrl_reg <= dat_i[15:0];
                    `ASP_REG_CSET: ctrl_reg <= ctrl_reg | dat_i[15:0];
                    `ASP_REG_CCLR: ctrl_reg <= ctrl_reg & ~dat_i[15:0];
                    `ASP_REG_DIV: div_reg <= (dat_i[15:0] == 16'h0) ? `ASP_DIV_RST : dat_i[15:0];
                    `ASP_REG_MASK: mask_reg <= dat_i[`ASP_NIRQ-1:0];
                    default: ;
                endcase
            end
            dat_o <= 32'h0;
            if (rd) begin
                case (adr_i)
                    `ASP_REG_DATA: dat_o <= rempty ? 32'h0 : {21'h0, rxf[ptr(rrp_reg)]};
                    `ASP_REG_CTRL: dat_o <= {16'h0, ctrl_reg};
                    `ASP_REG_DIV: dat_o <= {16'h0, div_reg};
                    `ASP_REG_STAT: dat_o <= {16'h0, rcnt[AW:0], tcnt[AW:0], 1'b0,
                                             ~cts_s2_reg, rfull, ~rempty, tfull, tempty};
                    `ASP_REG_IRQ: dat_o <= {26'h0, ist_reg};
                    `ASP_REG_MASK: dat_o <= {26'h0, mask_reg};
                    default: dat_o <= 32'h0;
                endcase
            end
        end
    end

    // synchronisers and baud tick
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_s1_reg <= 1'b1;
            rx_s2_reg <= 1'b1;
            cts_s1_reg <= 1'b1;
            cts_s2_reg <= 1'b1;
        end else begin
            rx_s1_reg <= rx_i;
            rx_s2_reg <= rx_s1_reg;
            cts_s1_reg <= cts_n_i;
            cts_s2_reg <= cts_s1_reg;
        end
    end
    always @(posedge clk_i) begin
        if (srst) begin
            bcnt_reg <= 16'h0;
            tick_reg <= 1'b0;
        end else if (bcnt_reg >= div_reg - 16'h1) begin
            bcnt_reg <= 16'h0;
            tick_reg <= 1'b1;
        end else begin
            bcnt_reg <= bcnt_reg + 16'h1;
            tick_reg <= 1'b0;
        end
    end

    // transmitter
    localparam TS_IDLE = 2'h0, TS_START = 2'h1, TS_DATA = 2'h2, TS_STOP = 2'h3;
    reg [1:0] ts_reg;
    reg [3:0] tos_reg;
    reg [3:0] tbit_reg;
    reg [8:0] tsh_reg;
    reg [4:0] tstop_reg;
    reg tline_reg;
    wire [7:0] thead = txf[ptr(trp_reg)];
    wire cts_ok = ~ctrl_reg[`ASP_C_FLOW] | ~cts_s2_reg;
    wire tpar = ^(thead & ~(8'hff << nbits)) ^ ~ctrl_reg[`ASP_C_EVEN];
    wire [3:0] tlen = nbits + {3'h0, ctrl_reg[`ASP_C_PEN]};
    wire tx_pop = (ts_reg == TS_IDLE) & tick_reg & ~tempty & cts_ok;
    always @(posedge clk_i) begin
        if (srst) begin
            ts_reg <= TS_IDLE;
            tos_reg <= 4'h0;
            tbit_reg <= 4'h0;
            tsh_reg <= 9'h1ff;
            tstop_reg <= 5'h0;
            tline_reg <= 1'b1;
        end else if (tick_reg) begin
            tos_reg <= tos_reg + 4'h1;
            case (ts_reg)
                TS_IDLE: begin
                    tos_reg <= 4'h0;
                    tline_reg <= 1'b1;
                    if (tx_pop) begin
                        ts_reg <= TS_START;
                        tline_reg <= 1'b0;
                        tsh_reg <= {1'b1, thead} & ~(9'h1ff << nbits) |
                                   ({8'h0, tpar & ctrl_reg[`ASP_C_PEN]} << nbits);
                        tbit_reg <= 4'h0;
                    end
                end
                TS_START: if (tos_reg == `ASP_OS_LAST) begin
                    ts_reg <= TS_DATA;
                    tline_reg <= tsh_reg[0];
                end
                TS_DATA: if (tos_reg == `ASP_OS_LAST) begin
                    tsh_reg <= {1'b1, tsh_reg[8:1]};
                    tbit_reg <= tbit_reg + 4'h1;
                    if (tbit_reg == tlen - 4'h1) begin
                        ts_reg <= TS_STOP;
                        tline_reg <= 1'b1;
                        tstop_reg <= 5'h0;
                    end else
                        tline_reg <= tsh_reg[1];
                end
                TS_STOP: begin
                    tstop_reg <= tstop_reg + 5'h1;
                    // stop length: 16, 24 or 32 oversample ticks
                    if (tstop_reg == {1'b0, `ASP_OS_LAST} + (ctrl_reg[`ASP_C_STOP_HI:`ASP_C_STOP_LO] == 2'h1 ?
                        `ASP_STOP_MID : ctrl_reg[`ASP_C_STOP_HI:`ASP_C_STOP_LO] == 2'h2 ? `ASP_STOP_TWO : 5'h0))
                        ts_reg <= TS_IDLE;
                end
                default: ts_reg <= TS_IDLE;
            endcase
        end
    end

    // receiver
    localparam RS_IDLE = 2'h0, RS_START = 2'h1, RS_DATA = 2'h2, RS_STOP = 2'h3;
    reg [1:0] rs_reg;
    reg [3:0] ros_reg;
    reg [3:0] rbit_reg;
    reg [8:0] rsh_reg;
    reg [3:0] irw_reg;
    reg rx_push_reg;
    reg [10:0] rword_reg;
    reg rwait_reg;
    // ir pulse stretched to a bit-length low so the uart core sees plain nrz
    wire rline = ir ? (irw_reg == 4'h0) : rx_s2_reg;
    wire [3:0] rlen = nbits + {3'h0, ctrl_reg[`ASP_C_PEN]};
    always @(posedge clk_i) begin
        if (srst)
            irw_reg <= 4'h0;
        else if (ir & rx_s2_reg)
            irw_reg <= `ASP_OS_LAST;
        else if (tick_reg & irw_reg != 4'h0)
            irw_reg <= irw_reg - 4'h1;
    end
    always @(posedge clk_i) begin
        if (srst) begin
            rs_reg <= RS_IDLE;
            ros_reg <= 4'h0;
            rbit_reg <= 4'h0;
            rsh_reg <= 9'h0;
            rx_push_reg <= 1'b0;
            rword_reg <= 11'h0;
            rwait_reg <= 1'b0;
        end else begin
            rx_push_reg <= 1'b0;
            if (rline)
                rwait_reg <= 1'b0;
            if (tick_reg) begin
                ros_reg <= ros_reg + 4'h1;
                case (rs_reg)
                    RS_IDLE: begin
                        ros_reg <= 4'h0;
                        if (~rline & ~rwait_reg)
                            rs_reg <= RS_START;
                    end
                    RS_START: if (ros_reg == `ASP_OS_MID) begin
                        ros_reg <= 4'h0;
                        rbit_reg <= 4'h0;
                        rsh_reg <= 9'h0;
                        rs_reg <= rline ? RS_IDLE : RS_DATA;
                    end
                    RS_DATA: if (ros_reg == `ASP_OS_LAST) begin
                        rsh_reg[rbit_reg] <= rline;
                        rbit_reg <= rbit_reg + 4'h1;
                        if (rbit_reg == rlen - 4'h1)
                            rs_reg <= RS_STOP;
                    end
                    RS_STOP: if (ros_reg == `ASP_OS_LAST) begin
                        rs_reg <= RS_IDLE;
                        rx_push_reg <= 1'b1;
                        // a long break must not restart the receiver until the line idles
                        rwait_reg <= ~rline;
                        // {break, frame err, parity err, data}
                        rword_reg <= {~rline & (rsh_reg == 9'h0), ~rline,
                                      ctrl_reg[`ASP_C_PEN] & (^(rsh_reg & ~(9'h1fe << nbits)) ^
                                      ~ctrl_reg[`ASP_C_EVEN]),
                                      rsh_reg[7:0] & ~(8'hff << nbits)};
                    end
                    default: rs_reg <= RS_IDLE;
                endcase
            end
        end
    end

    // fifos
    always @(posedge clk_i) begin
        if (srst) begin
            twp_reg <= {(AW+1){1'b0}};
            trp_reg <= {(AW+1){1'b0}};
            rwp_reg <= {(AW+1){1'b0}};
            rrp_reg <= {(AW+1){1'b0}};
        end else begin
            if (tx_push) begin
                txf[ptr(twp_reg)] <= dat_i[7:0];
                twp_reg <= twp_reg + 1'b1;
            end
            if (tx_pop)
                trp_reg <= trp_reg + 1'b1;
            if (rx_push_reg & ~rfull) begin
                rxf[ptr(rwp_reg)] <= rword_reg;
                rwp_reg <= rwp_reg + 1'b1;
            end
            if (rx_pop)
                rrp_reg <= rrp_reg + 1'b1;
        end
    end

    // events, interrupt, dma, pins; hardware set wins over write-one clear
    reg tempty_d_reg;
    wire [`ASP_NIRQ-1:0] ev = {rx_push_reg & rfull,
                              rx_push_reg & rword_reg[10],
                              rx_push_reg & rword_reg[9] & ~rword_reg[10],
                              rx_push_reg & rword_reg[8],
                              rx_push_reg,
                              tempty & ~tempty_d_reg};
    wire [`ASP_NIRQ-1:0] w1c = (wr & adr_i == `ASP_REG_IRQ) ? dat_i[`ASP_NIRQ-1:0] : {`ASP_NIRQ{1'b0}};
    wire [3:0] irpw = ctrl_reg[`ASP_C_IRLP] ? `ASP_IRLP_PW : `ASP_IR_PW;
    always @(posedge clk_i) begin
        if (srst) begin
            ist_reg <= {`ASP_NIRQ{1'b0}};
            tempty_d_reg <= 1'b1;
            irq_o <= 1'b0;
            dma_tx_req_o <= 1'b0;
            dma_rx_req_o <= 1'b0;
            rts_n_o <= 1'b1;
            tx_o <= 1'b1;
        end else begin
            tempty_d_reg <= tempty;
            ist_reg <= (ist_reg & ~w1c) | ev;
            irq_o <= |(ist_reg & mask_reg);
            dma_tx_req_o <= ~tfull & ~(tx_push & tcnt == DEPTH - 1);
            dma_rx_req_o <= ~rempty & ~(rx_pop & rcnt == 1);
            rts_n_o <= ~(ctrl_reg[`ASP_C_RTS] & (~ctrl_reg[`ASP_C_FLOW] | ~rfull));
            if (ctrl_reg[`ASP_C_BRK])
                tx_o <= ir;
            else if (ir)
                tx_o <= ~tline_reg & (ts_reg != TS_IDLE) & (tos_reg <= irpw);
            else
                tx_o <= tline_reg;
        end
    end
endmodule
